/* inc/ifm_irq_map.vh */
// register map, field positions and vector codes of the interrupt flag and mask block
// assumes word-aligned Avalon-MM byte addresses, 8-bit data in the low lane
`ifndef IFM_IRQ_MAP_VH
`define IFM_IRQ_MAP_VH
`define IFM_ADDR_W            8
`define IFM_OFS_TMR_FLAGS     8'h38
`define IFM_OFS_GEN_FLAGS     8'h3c
`define IFM_OFS_GEN_MASK      8'h40
`define IFM_OFS_TMR_MASK      8'h44
`define IFM_OFS_CMP_A         8'h48
`define IFM_OFS_CMP_B         8'h4c
`define IFM_OFS_CTRL          8'h50
`define IFM_OFS_AMASK_A       8'h54
`define IFM_OFS_AMASK_B       8'h58
`define IFM_BIT_EXT_FLAG      6
`define IFM_BIT_PC_FLAG       5
`define IFM_BIT_EXT_EN        6
`define IFM_BIT_PC_EN1        5
`define IFM_BIT_PC_EN0        4
`define IFM_BIT_CMP_A         6
`define IFM_BIT_CMP_B         5
`define IFM_BIT_T1OVF         2
`define IFM_BIT_T0OVF         1
`define IFM_BIT_CTRL_GIE      0
`define IFM_BIT_CTRL_LEVEL    1
`define IFM_GEN_MASK_WMASK    8'h70
`define IFM_TMR_MASK_WMASK    8'h66
`define IFM_PA_PC_PINS        8'hc8
`define IFM_RESET_BYTE        8'h00
`define IFM_PRIME_CNT         2'h3
`define IFM_VEC_NONE          3'h0
`define IFM_VEC_EXT           3'h1
`define IFM_VEC_PC            3'h2
`define IFM_VEC_CMP_A         3'h3
`define IFM_VEC_CMP_B         3'h4
`define IFM_VEC_T1OVF         3'h5
`define IFM_VEC_T0OVF         3'h6
`endif

/* core/ifm_irq_flags.v */
// interrupt flags, enables and vector request logic with an Avalon-MM register slave
// assumes event strobes are one-cycle pulses on I_CLOCK; pins arrive asynchronously
//
// Summary of operation
// - set external flag on external pin event
// - external flag, enable, global request vector 1
// - vector entry or written one clears flags
// - level sensing holds external flag cleared
// - set pin-change flag on unmasked pin change
// - group enables gate which pins set flag
// - alternate function masks individual pin changes
// - pin-change flag, enable, global request vector 2
// - compare-A enable, flag, global request vector 3
// - compare-B enable, flag, global request vector 4
// - timer-1 overflow enabled requests vector 5
// - timer-0 overflow enabled requests vector 6
// - compare-A match sets compare-A flag
// - compare-B match sets compare-B flag
// - counter overflows set overflow flags
// - vector execution clears its timer flag
// - timer-1 flag write clears one cycle later
// - timer-0 flag write clears immediately
// - group enables at mask bits 5, 4
//
// The Avalon-MM register port was left to the implementer.
`include "ifm_irq_map.vh"
`default_nettype none
module ifm_irq_flags #(
  parameter CNT_W = 8
) (
  input  wire                   I_CLOCK,
  input  wire                   I_RST,
  input  wire [`IFM_ADDR_W-1:0] I_ADDRESS,
  input  wire                   I_READ,
  input  wire                   I_WRITE,
  input  wire [7:0]             I_WRITEDATA,
  output reg  [7:0]             O_READDATA,
  output reg                    O_WAITREQUEST,
  input  wire                   I_EXT_EVENT,
  input  wire [7:0]             I_PORTB_PINS,
  input  wire [7:0]             I_PORTA_PINS,
  input  wire [CNT_W-1:0]       I_TMR1_COUNT,
  input  wire                   I_TMR1_OVF,
  input  wire                   I_TMR0_OVF,
  input  wire                   I_VEC_ACK,
  input  wire [2:0]             I_VEC_ACK_NUM,
  output reg                    O_IRQ_REQ,
  output reg  [2:0]             O_IRQ_VECTOR
);
  // register file
  reg  [7:0]       gen_mask_r;
  reg  [7:0]       tmr_mask_r;
  reg  [CNT_W-1:0] cmp_a_value_r;
  reg  [CNT_W-1:0] cmp_b_value_r;
  reg              gie_r;
  reg              level_mode_r;
  reg  [7:0]       amask_b_r;
  reg  [7:0]       amask_a_r;
  reg              ext_pin_flag_r;
  reg              pin_change_flag_r;
  reg              cmp_a_flag_r;
  reg              cmp_b_flag_r;
  reg              tmr1_ovf_flag_r;
  reg              tmr0_ovf_flag_r;
  reg  [2:0]       t1_clr_pend_r;
  reg              ack_phase_r;
  // pin synchronisers: three stages, a change counts once stages two and three agree on a new level
  reg  [7:0]       pb_s1_r;
  reg  [7:0]       pb_s2_r;
  reg  [7:0]       pb_s3_r;
  reg  [7:0]       pa_s1_r;
  reg  [7:0]       pa_s2_r;
  reg  [7:0]       pa_s3_r;
  reg  [7:0]       pb_stable_r;
  reg  [7:0]       pa_stable_r;
  reg  [1:0]       prime_cnt_r;
  wire             primed;
  wire [7:0]       pb_raw;
  wire [7:0]       pa_raw;
  wire [7:0]       pb_chg;
  wire [7:0]       pa_chg;
  wire [7:0]       pb_grp_en;
  wire [7:0]       pa_grp_en;
  wire             pc_event;
  wire             wr_hit;
  wire             rd_hit;
  wire             wr_tflags;
  wire             wr_gflags;
  wire             ack_ext;
  wire             ack_pc;
  wire             ack_cmp_a;
  wire             ack_cmp_b;
  wire             ack_t1;
  wire             ack_t0;
  wire             req_ext;
  wire             req_pc;
  wire             req_cmp_a;
  wire             req_cmp_b;
  wire             req_t1;
  wire             req_t0;
  reg  [2:0]       vec_nxt;
  reg  [7:0]       rdata_nxt;

  function is_ack;
    input       ack;
    input [2:0] num;
    input [2:0] code;
    begin
      is_ack = ack && (num == code);
    end
  endfunction

  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      pb_s1_r     <= `IFM_RESET_BYTE;
      pb_s2_r     <= `IFM_RESET_BYTE;
      pb_s3_r     <= `IFM_RESET_BYTE;
      pb_stable_r <= `IFM_RESET_BYTE;
    end else begin
      pb_s1_r     <= I_PORTB_PINS;
      pb_s2_r     <= pb_s1_r;
      pb_s3_r     <= pb_s2_r;
      // while priming the accepted level follows the pipe, so pins idling high raise no flag
      pb_stable_r <= primed ? (pb_stable_r ^ pb_raw) : pb_s2_r;
    end
  end

  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      pa_s1_r     <= `IFM_RESET_BYTE;
      pa_s2_r     <= `IFM_RESET_BYTE;
      pa_s3_r     <= `IFM_RESET_BYTE;
      pa_stable_r <= `IFM_RESET_BYTE;
    end else begin
      pa_s1_r     <= I_PORTA_PINS;
      pa_s2_r     <= pa_s1_r;
      pa_s3_r     <= pa_s2_r;
      pa_stable_r <= primed ? (pa_stable_r ^ pa_raw) : pa_s2_r;
    end
  end

  // the pipe needs three edges after reset to fill; no change counts before that
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      prime_cnt_r <= 2'h0;
    end else if (!primed) begin
      prime_cnt_r <= prime_cnt_r + 2'h1;
    end
  end
  assign primed = (prime_cnt_r == `IFM_PRIME_CNT);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_grp
      assign pb_grp_en[gi] = (gi >= 4) ? gen_mask_r[`IFM_BIT_PC_EN1] : gen_mask_r[`IFM_BIT_PC_EN0];
      assign pa_grp_en[gi] = gen_mask_r[`IFM_BIT_PC_EN1];
    end
  endgenerate
  // masked pins still update their accepted level, so unmasking later raises no stale change
  assign pb_raw   = ~(pb_s2_r ^ pb_s3_r) & (pb_s3_r ^ pb_stable_r);
  assign pa_raw   = ~(pa_s2_r ^ pa_s3_r) & (pa_s3_r ^ pa_stable_r);
  assign pb_chg   = pb_raw & pb_grp_en & ~amask_b_r;
  assign pa_chg   = pa_raw & pa_grp_en & ~amask_a_r & `IFM_PA_PC_PINS;
  assign pc_event = primed && ((|pb_chg) || (|pa_chg));

  // bus slave: one wait cycle, answer on the second cycle of the request
  assign rd_hit    = I_READ && O_WAITREQUEST;
  assign wr_hit    = I_WRITE && O_WAITREQUEST;
  assign wr_tflags = wr_hit && (I_ADDRESS == `IFM_OFS_TMR_FLAGS);
  assign wr_gflags = wr_hit && (I_ADDRESS == `IFM_OFS_GEN_FLAGS);

  assign ack_ext   = is_ack(I_VEC_ACK, I_VEC_ACK_NUM, `IFM_VEC_EXT);
  assign ack_pc    = is_ack(I_VEC_ACK, I_VEC_ACK_NUM, `IFM_VEC_PC);
  assign ack_cmp_a = is_ack(I_VEC_ACK, I_VEC_ACK_NUM, `IFM_VEC_CMP_A);
  assign ack_cmp_b = is_ack(I_VEC_ACK, I_VEC_ACK_NUM, `IFM_VEC_CMP_B);
  assign ack_t1    = is_ack(I_VEC_ACK, I_VEC_ACK_NUM, `IFM_VEC_T1OVF);
  assign ack_t0    = is_ack(I_VEC_ACK, I_VEC_ACK_NUM, `IFM_VEC_T0OVF);

  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_WAITREQUEST <= 1'b1;
      ack_phase_r   <= 1'b0;
    end else begin
      ack_phase_r   <= (I_READ || I_WRITE) && !ack_phase_r;
      O_WAITREQUEST <= !((I_READ || I_WRITE) && !ack_phase_r);
    end
  end

  // control registers; a write is taken at the edge where waitrequest is low
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      gen_mask_r    <= `IFM_RESET_BYTE;
      tmr_mask_r    <= `IFM_RESET_BYTE;
      cmp_a_value_r <= {CNT_W{1'b0}};
      cmp_b_value_r <= {CNT_W{1'b0}};
      gie_r         <= 1'b0;
      level_mode_r  <= 1'b0;
      amask_b_r     <= `IFM_RESET_BYTE;
      amask_a_r     <= `IFM_RESET_BYTE;
    end else if (I_WRITE && !O_WAITREQUEST) begin
      case (I_ADDRESS)
        `IFM_OFS_GEN_MASK: gen_mask_r <= I_WRITEDATA & `IFM_GEN_MASK_WMASK;
        `IFM_OFS_TMR_MASK: tmr_mask_r <= I_WRITEDATA & `IFM_TMR_MASK_WMASK;
        `IFM_OFS_CMP_A:    cmp_a_value_r <= I_WRITEDATA[CNT_W-1:0];
        `IFM_OFS_CMP_B:    cmp_b_value_r <= I_WRITEDATA[CNT_W-1:0];
        `IFM_OFS_CTRL: begin
          gie_r        <= I_WRITEDATA[`IFM_BIT_CTRL_GIE];
          level_mode_r <= I_WRITEDATA[`IFM_BIT_CTRL_LEVEL];
        end
        `IFM_OFS_AMASK_B:  amask_b_r <= I_WRITEDATA;
        `IFM_OFS_AMASK_A:  amask_a_r <= I_WRITEDATA & `IFM_PA_PC_PINS;
        default: ;
      endcase
    end
  end

  // flags: a set in the same cycle as a clear wins, but a timer-1 set in the cycle of its flag write is still cleared
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ext_pin_flag_r <= 1'b0;
    end else if (level_mode_r) begin
      // level sensing keeps the flag low, so no external request is raised in this mode
      ext_pin_flag_r <= 1'b0;
    end else if (I_EXT_EVENT) begin
      ext_pin_flag_r <= 1'b1;
    end else if (ack_ext || (wr_gflags && I_WRITEDATA[`IFM_BIT_EXT_FLAG])) begin
      ext_pin_flag_r <= 1'b0;
    end
  end

  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      pin_change_flag_r <= 1'b0;
    end else if (pc_event) begin
      pin_change_flag_r <= 1'b1;
    end else if (ack_pc || (wr_gflags && I_WRITEDATA[`IFM_BIT_PC_FLAG])) begin
      pin_change_flag_r <= 1'b0;
    end
  end

  // timer-1 flag write clears are held one cycle before they act
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      t1_clr_pend_r <= 3'h0;
    end else if (wr_tflags) begin
      t1_clr_pend_r <= {I_WRITEDATA[`IFM_BIT_CMP_A], I_WRITEDATA[`IFM_BIT_CMP_B], I_WRITEDATA[`IFM_BIT_T1OVF]};
    end else begin
      t1_clr_pend_r <= 3'h0;
    end
  end

  // compare flags set again on every cycle the count still matches
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      cmp_a_flag_r <= 1'b0;
      cmp_b_flag_r <= 1'b0;
    end else begin
      if (I_TMR1_COUNT == cmp_a_value_r) begin
        cmp_a_flag_r <= 1'b1;
      end else if (ack_cmp_a || t1_clr_pend_r[2]) begin
        cmp_a_flag_r <= 1'b0;
      end
      if (I_TMR1_COUNT == cmp_b_value_r) begin
        cmp_b_flag_r <= 1'b1;
      end else if (ack_cmp_b || t1_clr_pend_r[1]) begin
        cmp_b_flag_r <= 1'b0;
      end
    end
  end

  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      tmr1_ovf_flag_r <= 1'b0;
      tmr0_ovf_flag_r <= 1'b0;
    end else begin
      if (I_TMR1_OVF) begin
        tmr1_ovf_flag_r <= 1'b1;
      end else if (ack_t1 || t1_clr_pend_r[0]) begin
        tmr1_ovf_flag_r <= 1'b0;
      end
      // timer 0 runs on this clock, so its write clear needs no extra stage
      if (I_TMR0_OVF) begin
        tmr0_ovf_flag_r <= 1'b1;
      end else if (ack_t0 || (wr_tflags && I_WRITEDATA[`IFM_BIT_T0OVF])) begin
        tmr0_ovf_flag_r <= 1'b0;
      end
    end
  end

  assign req_ext   = gie_r && gen_mask_r[`IFM_BIT_EXT_EN] && ext_pin_flag_r;
  // one enable is the flag mask for each group, so the request needs either set
  assign req_pc    = gie_r && (gen_mask_r[`IFM_BIT_PC_EN1] || gen_mask_r[`IFM_BIT_PC_EN0]) && pin_change_flag_r;
  assign req_cmp_a = gie_r && tmr_mask_r[`IFM_BIT_CMP_A] && cmp_a_flag_r;
  assign req_cmp_b = gie_r && tmr_mask_r[`IFM_BIT_CMP_B] && cmp_b_flag_r;
  assign req_t1    = gie_r && tmr_mask_r[`IFM_BIT_T1OVF] && tmr1_ovf_flag_r;
  assign req_t0    = gie_r && tmr_mask_r[`IFM_BIT_T0OVF] && tmr0_ovf_flag_r;

  always @* begin
    vec_nxt = `IFM_VEC_NONE;
    if (req_ext)
      vec_nxt = `IFM_VEC_EXT;
    else if (req_pc)
      vec_nxt = `IFM_VEC_PC;
    else if (req_cmp_a)
      vec_nxt = `IFM_VEC_CMP_A;
    else if (req_cmp_b)
      vec_nxt = `IFM_VEC_CMP_B;
    else if (req_t1)
      vec_nxt = `IFM_VEC_T1OVF;
    else if (req_t0)
      vec_nxt = `IFM_VEC_T0OVF;
  end

  always @* begin
    rdata_nxt = `IFM_RESET_BYTE;
    case (I_ADDRESS)
      `IFM_OFS_TMR_FLAGS: begin
        rdata_nxt[`IFM_BIT_CMP_A] = cmp_a_flag_r;
        rdata_nxt[`IFM_BIT_CMP_B] = cmp_b_flag_r;
        rdata_nxt[`IFM_BIT_T1OVF] = tmr1_ovf_flag_r;
        rdata_nxt[`IFM_BIT_T0OVF] = tmr0_ovf_flag_r;
      end
      `IFM_OFS_GEN_FLAGS: begin
        rdata_nxt[`IFM_BIT_EXT_FLAG] = ext_pin_flag_r;
        rdata_nxt[`IFM_BIT_PC_FLAG]  = pin_change_flag_r;
      end
      `IFM_OFS_GEN_MASK: rdata_nxt = gen_mask_r;
      `IFM_OFS_TMR_MASK: rdata_nxt = tmr_mask_r;
      `IFM_OFS_CMP_A:    rdata_nxt[CNT_W-1:0] = cmp_a_value_r;
      `IFM_OFS_CMP_B:    rdata_nxt[CNT_W-1:0] = cmp_b_value_r;
      `IFM_OFS_CTRL: begin
        rdata_nxt[`IFM_BIT_CTRL_GIE]   = gie_r;
        rdata_nxt[`IFM_BIT_CTRL_LEVEL] = level_mode_r;
      end
      `IFM_OFS_AMASK_B:  rdata_nxt = amask_b_r;
      `IFM_OFS_AMASK_A:  rdata_nxt = amask_a_r;
      default:           rdata_nxt = `IFM_RESET_BYTE;
    endcase
  end

  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_READDATA   <= `IFM_RESET_BYTE;
      O_IRQ_REQ    <= 1'b0;
      O_IRQ_VECTOR <= `IFM_VEC_NONE;
    end else begin
      if (rd_hit)
        O_READDATA <= rdata_nxt;
      // an acknowledged vector is dropped at once so it is not fetched twice
      O_IRQ_REQ    <= (vec_nxt != `IFM_VEC_NONE) && !I_VEC_ACK;
      O_IRQ_VECTOR <= I_VEC_ACK ? `IFM_VEC_NONE : vec_nxt;
    end
  end
endmodule
`default_nettype wire

/* dv/ifm_irq_flags_asserts.sv */
// port checker for the interrupt flag block
// assumes the register map header is on the include path
`include "ifm_irq_map.vh"
`default_nettype none
module ifm_irq_flags_asserts (
  input wire logic                   I_CLOCK,
  input wire logic                   I_RST,
  input wire logic [`IFM_ADDR_W-1:0] I_ADDRESS,
  input wire logic                   I_READ,
  input wire logic                   I_WRITE,
  input wire logic [7:0]             O_READDATA,
  input wire logic                   O_WAITREQUEST,
  input wire logic                   I_VEC_ACK,
  input wire logic                   O_IRQ_REQ,
  input wire logic [2:0]             O_IRQ_VECTOR
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  wire logic rd_done = I_READ && !O_WAITREQUEST;
  a_bus_answer: assert property ((I_READ || I_WRITE) && O_WAITREQUEST |=> !O_WAITREQUEST)
    else $error("bus request not answered next cycle");
  a_wait_pulse: assert property (!O_WAITREQUEST |=> O_WAITREQUEST)
    else $error("waitrequest low too long");
  a_ack_drops: assert property (I_VEC_ACK |=> !O_IRQ_REQ)
    else $error("request stays after vector entry");
  a_idle_vector: assert property (!O_IRQ_REQ |-> O_IRQ_VECTOR == `IFM_VEC_NONE)
    else $error("vector shown without request");
  a_vector_range: assert property (O_IRQ_REQ |-> O_IRQ_VECTOR inside {[1:6]})
    else $error("vector out of range");
  a_gflag_rsvd: assert property (rd_done && I_ADDRESS == `IFM_OFS_GEN_FLAGS |-> (O_READDATA & 8'h9f) == 8'h00)
    else $error("reserved general flag bit set");
  a_tflag_rsvd: assert property (rd_done && I_ADDRESS == `IFM_OFS_TMR_FLAGS |-> (O_READDATA & 8'h99) == 8'h00)
    else $error("reserved timer flag bit set");
  a_tmask_rsvd: assert property (rd_done && I_ADDRESS == `IFM_OFS_TMR_MASK |-> (O_READDATA & 8'h99) == 8'h00)
    else $error("reserved timer mask bit set");
  a_gmask_place: assert property (rd_done && I_ADDRESS == `IFM_OFS_GEN_MASK |-> (O_READDATA & 8'h8f) == 8'h00)
    else $error("general mask bit outside enables");
  a_rdata_hold: assert property (!I_READ |=> $stable(O_READDATA))
    else $error("read data moved without a read");
  c_vec_ext: cover property (O_IRQ_REQ && O_IRQ_VECTOR == `IFM_VEC_EXT);
  c_vec_t0: cover property (O_IRQ_REQ && O_IRQ_VECTOR == `IFM_VEC_T0OVF);
  c_ack: cover property (I_VEC_ACK);
endmodule
bind ifm_irq_flags ifm_irq_flags_asserts u_chk (.I_CLOCK, .I_RST, .I_ADDRESS, .I_READ, .I_WRITE,
  .O_READDATA, .O_WAITREQUEST, .I_VEC_ACK, .O_IRQ_REQ, .O_IRQ_VECTOR);
`default_nettype wire

/* dv/ifm_cpu_model.sv */
// cpu side model: enters the presented vector after a set delay
// assumes request and vector are registered outputs on the same clock
`default_nettype none
module ifm_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_en,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_irq_req,
  input  wire logic [2:0] i_irq_vec,
  output var  logic       o_ack,
  output var  logic [2:0] o_ack_num
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_ack_num <= 3'h0;
      wait_r <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      // hold off while the last entry is still being taken
      if (o_ack || !i_en || !i_irq_req) begin
        wait_r <= 4'h0;
      end else if (wait_r >= i_delay) begin
        o_ack <= 1'b1;
        o_ack_num <= i_irq_vec;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/test_ifm_irq_flags.sv */
// self-checking bench for the interrupt flag and mask block
// assumes a cpu model answers vectors; bench drives bus and event inputs
`include "ifm_irq_map.vh"
`default_nettype none
module test_ifm_irq_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, rd, wr, ext, t1o, t0o, en;
  logic [7:0] adr, wd, pb, pa, cnt, q;
  logic [3:0] dly;
  wire        wq, ack, req;
  wire  [7:0] rdat;
  wire  [2:0] vec, anum;
  int         miscompares, tests_run;
  logic [2:0] log_q[$];
  ifm_irq_flags DUT (.I_CLOCK(clk), .I_RST(rst), .I_ADDRESS(adr), .I_READ(rd), .I_WRITE(wr),
    .I_WRITEDATA(wd), .O_READDATA(rdat), .O_WAITREQUEST(wq), .I_EXT_EVENT(ext), .I_PORTB_PINS(pb),
    .I_PORTA_PINS(pa), .I_TMR1_COUNT(cnt), .I_TMR1_OVF(t1o), .I_TMR0_OVF(t0o), .I_VEC_ACK(ack),
    .I_VEC_ACK_NUM(anum), .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec));
  ifm_cpu_model u_cpu (.i_clk(clk), .i_rst(rst), .i_en(en), .i_delay(dly), .i_irq_req(req),
    .i_irq_vec(vec), .o_ack(ack), .o_ack_num(anum));
  always @(posedge clk) if (ack === 1'b1) log_q.push_back(anum);
  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wq !== 1'b0) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic evt(input logic e, input logic c, input logic z);
    @(posedge clk);
    ext <= e;
    t1o <= c;
    t0o <= z;
    @(posedge clk);
    {ext, t1o, t0o} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic pin(input logic [7:0] b, input logic [7:0] a);
    @(posedge clk);
    pb <= b;
    pa <= a;
    repeat (8) @(posedge clk);
  endtask
  // both overflows, then one cycle each of compare A and compare B
  task automatic fire_tmr;
    evt(1'b0, 1'b1, 1'b1);
    @(posedge clk);
    cnt <= 8'h10;
    @(posedge clk);
    cnt <= 8'h20;
    @(posedge clk);
    cnt <= 8'hff;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs;
    rdc(`IFM_OFS_TMR_FLAGS, 8'h00);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
    bus(1'b1, `IFM_OFS_TMR_MASK, 8'hff);
    rdc(`IFM_OFS_TMR_MASK, 8'h66);
    bus(1'b1, `IFM_OFS_GEN_MASK, 8'hff);
    rdc(`IFM_OFS_GEN_MASK, 8'h70);
    rdc(8'h7c, 8'h00);
  endtask
  task automatic t_timer;
    bus(1'b1, `IFM_OFS_CMP_A, 8'h10);
    bus(1'b1, `IFM_OFS_CMP_B, 8'h20);
    evt(1'b0, 1'b1, 1'b1);
    rdc(`IFM_OFS_TMR_FLAGS, 8'h06);
    fire_tmr();
    rdc(`IFM_OFS_TMR_FLAGS, 8'h66);
    bus(1'b1, `IFM_OFS_TMR_FLAGS, 8'h00);
    rdc(`IFM_OFS_TMR_FLAGS, 8'h66);
    bus(1'b1, `IFM_OFS_TMR_FLAGS, 8'h02);
    rdc(`IFM_OFS_TMR_FLAGS, 8'h64);
    bus(1'b1, `IFM_OFS_TMR_FLAGS, 8'h64);
    rdc(`IFM_OFS_TMR_FLAGS, 8'h00);
  endtask
  task automatic t_vectors;
    fire_tmr();
    log_q.delete();
    dly <= 4'h3;
    en <= 1'b1;
    bus(1'b1, `IFM_OFS_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    chk(8'(log_q.size()), 8'h04);
    for (int i = 0; i < log_q.size(); i++) chk({5'h0, log_q[i]}, 8'(i + 3));
    rdc(`IFM_OFS_TMR_FLAGS, 8'h00);
    en <= 1'b0;
    bus(1'b1, `IFM_OFS_CTRL, 8'h00);
  endtask
  task automatic t_ext;
    bus(1'b1, `IFM_OFS_GEN_MASK, 8'h40);
    evt(1'b1, 1'b0, 1'b0);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h40);
    bus(1'b1, `IFM_OFS_GEN_FLAGS, 8'h00);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h40);
    bus(1'b1, `IFM_OFS_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    chk({4'h0, req, vec}, 8'h09);
    bus(1'b1, `IFM_OFS_GEN_FLAGS, 8'h40);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
    evt(1'b1, 1'b0, 1'b0);
    bus(1'b1, `IFM_OFS_CTRL, 8'h02);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
    evt(1'b1, 1'b0, 1'b0);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
  endtask
  task automatic t_pc;
    bus(1'b1, `IFM_OFS_CTRL, 8'h00);
    bus(1'b1, `IFM_OFS_GEN_MASK, 8'h10);
    pin(8'h10, 8'h00);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
    bus(1'b1, `IFM_OFS_AMASK_B, 8'h01);
    pin(8'h11, 8'h00);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
    pin(8'h13, 8'h00);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h20);
    bus(1'b1, `IFM_OFS_GEN_FLAGS, 8'h20);
    bus(1'b1, `IFM_OFS_GEN_MASK, 8'h20);
    pin(8'h13, 8'h01);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
    pin(8'h13, 8'h81);
    log_q.delete();
    dly <= 4'h0;
    en <= 1'b1;
    bus(1'b1, `IFM_OFS_CTRL, 8'h01);
    repeat (10) @(posedge clk);
    chk({4'h0, log_q.size() == 1, log_q[0]}, 8'h0a);
    rdc(`IFM_OFS_GEN_FLAGS, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, rd, wr, ext, t1o, t0o, en} = 7'h40;
    {adr, wd, pb, pa} = 32'h0;
    cnt = 8'hff;
    dly = 4'h0;
    miscompares = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_timer();
    t_vectors();
    t_ext();
    t_pc();
    close_out();
  end
endmodule
`default_nettype wire
